// File: bench/fsbr_array_model.sv
// Behavioural flash array answering the burst port's word address
module fsbr_array_model #(
	parameter int ADDR_W = 24
) (
	// Array read port
	input  wire logic [ADDR_W-1:0] array_addr,
	output logic      [15:0]       array_rdata
);
	// Word derived from its address so wrong ordering shows at once
	assign array_rdata = array_addr[15:0] ^ 16'h5A00;
endmodule : fsbr_array_model

// File: bench/tb_top.sv
// Self-checking bench for the synchronous burst read port
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [15:0] cfg;
		logic [4:0]  start;
		logic [19:0] seq;
	} fsbr_row_t;

	logic        mclk      = 1'b0;
	logic        rstn      = 1'b0;
	logic        fclk      = 1'b0;
	logic        adv_n     = 1'b1;
	logic        cs_n      = 1'b1;
	logic        oe_n      = 1'b1;
	logic        cfg_wr    = 1'b0;
	logic [23:0] addr      = 24'h0;
	logic [15:0] cfg_wdata = 16'h0;
	logic [15:0] data_out;
	logic [15:0] rcfg;
	logic [15:0] rdata;
	logic [23:0] aaddr;
	logic        data_oe;
	logic        wait_out;
	logic        wait_oe;
	int          n_mismatch = 0;
	int          cmp_count  = 0;

	// Latency 5 everywhere: host side picks a count that covers access time
	fsbr_row_t rows [6] = '{
		'{16'h2D41, 5'h1, {5'h1, 5'h2, 5'h3, 5'h0}},
		'{16'h2D49, 5'h1, {5'h1, 5'h2, 5'h3, 5'h4}},
		'{16'h2D42, 5'h5, {5'h5, 5'h6, 5'h7, 5'h0}},
		'{16'h2D47, 5'h4, {5'h4, 5'h5, 5'h6, 5'h7}},
		'{16'h2D43, 5'hE, {5'hE, 5'hF, 5'h0, 5'h1}},
		'{16'h2801, 5'h2, {5'h2, 5'h3, 5'h0, 5'h1}}
	};

`define CHK(what, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("ERROR %s expected %h seen %h", what, exp, got); \
		end \
	end

	// Device under test and its array
	fsbr_flash_burst fsbr_flash_burst_inst (
		.mclk               (mclk),
		.rstn               (rstn),
		.flash_clk          (fclk),
		.addr_valid_n       (adv_n),
		.chip_sel_n         (cs_n),
		.out_en_n           (oe_n),
		.addr_in            (addr),
		.data_out           (data_out),
		.data_oe            (data_oe),
		.wait_out           (wait_out),
		.wait_oe            (wait_oe),
		.cfg_wr             (cfg_wr),
		.cfg_wdata          (cfg_wdata),
		.read_configuration (rcfg),
		.array_addr         (aaddr),
		.array_rdata        (rdata)
	);
	fsbr_array_model fsbr_array_model_inst (
		.array_addr  (aaddr),
		.array_rdata (rdata)
	);

	always #50 mclk = ~mclk;

	// Inputs only move on falling edges, away from the sampling edge
	task automatic tick(int n);
		repeat (n) @(negedge mclk);
	endtask : tick

	// Bus clock slow against mclk so the pin synchronisers keep up
	task automatic fedge(logic act);
		fclk = ~act;
		tick(2);
		fclk = act;
		tick(6);
	endtask : fedge

	task automatic cfg_write(logic [15:0] v);
		cfg_wr    = 1'b1;
		cfg_wdata = v;
		tick(1);
		cfg_wr    = 1'b0;
	endtask : cfg_write

	task automatic final_report();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	// One capture, then eight selected edges watched for wait and data
	task automatic burst(fsbr_row_t r);
		logic        pol;
		logic        act;
		logic [15:0] exp;
		pol = r.cfg[10];
		act = r.cfg[6];
		cfg_write(r.cfg);
		fclk  = ~act;
		addr  = {19'h0, r.start};
		adv_n = 1'b0;
		cs_n  = 1'b0;
		oe_n  = 1'b0;
		tick(4);
		fedge(act);
		adv_n = 1'b1;
		for (int k = 1; k <= 8; k++) begin
			fedge(act);
			if (k == 1) begin
				`CHK("wait held", pol, wait_out)
				`CHK("wait driven", 1'b1, wait_oe)
				`CHK("data driven", 1'b1, data_oe)
			end
			if (k == 4)
				`CHK("wait delay", r.cfg[8] ? ~pol : pol, wait_out)
			if (k >= 5) begin
				exp = {11'h0, r.seq[19-5*(k-5) -: 5]} ^ 16'h5A00;
				`CHK("burst data", exp, data_out)
				`CHK("wait released", ~pol, wait_out)
			end
		end
		oe_n = 1'b1;
		tick(4);
		`CHK("wait float", 1'b0, wait_oe)
		cs_n = 1'b1;
		tick(4);
		$display("Burst cfg %h start %0d done", r.cfg, r.start);
	endtask : burst

	// Main sequence
	initial begin
		tick(5);
		rstn = 1'b1;
		tick(1);
		`CHK("cfg reset", 16'hFD4F, rcfg)
		`CHK("wait idle", 1'b0, wait_oe)
		cfg_write(16'hFFFF);
		`CHK("cfg mask", 16'hFD4F, rcfg)
		cfg_write(16'h0000);
		`CHK("cfg clear", 16'h0000, rcfg)
		$display("Reset and config test done");
		cfg_write(16'hFD4F);
		addr = 24'h7;
		cs_n = 1'b0;
		oe_n = 1'b0;
		tick(6);
		`CHK("page data", 16'h5A07, data_out)
		`CHK("page wait", 1'b0, wait_out)
		cs_n = 1'b1;
		oe_n = 1'b1;
		tick(4);
		$display("Page mode test done");
		foreach (rows[i]) begin
			burst(rows[i]);
		end
		// Row crossing: start at word 15, continuous, four wait edges before word 16
		cfg_write(16'h2D47);
		fclk  = 1'b0;
		addr  = 24'hF;
		adv_n = 1'b0;
		cs_n  = 1'b0;
		oe_n  = 1'b0;
		tick(4);
		fedge(1'b1);
		adv_n = 1'b1;
		for (int k = 1; k <= 10; k++) begin
			fedge(1'b1);
			if (k == 5)
				`CHK("row last word", 16'h5A0F, data_out)
			if (k == 7)
				`CHK("row wait", 1'b1, wait_out)
			if (k == 9)
				`CHK("row wait delay", 1'b0, wait_out)
			if (k == 10) begin
				`CHK("row next word", 16'h5A10, data_out)
				`CHK("row wait off", 1'b0, wait_out)
			end
		end
		oe_n = 1'b1;
		cs_n = 1'b1;
		tick(4);
		$display("Row crossing test done");
		cfg_write(16'h2D41);
		rstn = 1'b0;
		tick(5);
		rstn = 1'b1;
		tick(1);
		`CHK("cfg re-reset", 16'hFD4F, rcfg)
		`CHK("wait re-idle", 1'b0, wait_oe)
		`CHK("data re-idle", 1'b0, data_oe)
		$display("Mid-run reset test done");
		final_report();
	end

	// Watchdog against a hung sequence
	initial begin
		tick(20000);
		n_mismatch++;
		$display("ERROR watchdog expected finish seen hang");
		final_report();
	end
endmodule : tb_top

// File: rtl/fsbr_flash_burst.sv
// Read configuration and synchronous burst read sequencer of the flash bus port
`include "fsbr_params.svh"

module fsbr_flash_burst #(
	parameter int ADDR_W = 24
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rstn,
	// Flash bus pins from the host
	input  wire logic              flash_clk,
	input  wire logic              addr_valid_n,
	input  wire logic              chip_sel_n,
	input  wire logic              out_en_n,
	input  wire logic [ADDR_W-1:0] addr_in,
	// Data pins toward the host
	output logic      [15:0]       data_out,
	output logic                   data_oe,
	// Wait pin toward the host
	output logic                   wait_out,
	output logic                   wait_oe,
	// Configuration access from the command decoder
	input  wire logic              cfg_wr,
	input  wire logic [15:0]       cfg_wdata,
	output logic      [15:0]       read_configuration,
	// Array read port
	output logic      [ADDR_W-1:0] array_addr,
	input  wire logic [15:0]       array_rdata
);
	import fsbr_pkg::*;

	// Row alignment needs at least four word address bits plus one above
	if (ADDR_W < 5) begin : g_chk
		$error("fsbr_flash_burst: ADDR_W must be at least 5");
	end

	// Pin synchronisers and clock edge history
	logic [3:0]        pin_s1;
	logic [3:0]        pin_s2;
	logic [ADDR_W-1:0] addr_s1;
	logic [ADDR_W-1:0] addr_s2;
	logic              fclk_d;
	logic              fclk;
	logic              adv_n;
	logic              cs_n;
	logic              oe_n;
	logic              active;
	logic              edge_ok;

	// Sequencer state
	fsbr_state_t       state;
	fsbr_state_t       next_state;
	logic [4:0]        hold_cnt;
	logic [4:0]        next_hold_cnt;
	logic [4:0]        words_left;
	logic [4:0]        next_words_left;
	logic [4:0]        end_of_wordline_left;
	logic [4:0]        next_end_of_wordline_left;
	logic              wait_asrt;
	logic              next_wait_asrt;
	logic [ADDR_W-1:0] next_array_addr;
	logic [15:0]       next_data_out;
	logic              next_data_oe;
	logic              next_wait_out;
	logic              next_wait_oe;
	logic [15:0]       next_cfg;

	// Configuration fields
	logic              rm;
	logic [3:0]        lat_code;
	logic [3:0]        lat_eff;
	logic              wpol;
	logic              wdly;
	logic              edge_rise;
	logic              wrap_dis;
	logic [2:0]        bl;
	logic              capture;
	logic              deliver;
	logic [ADDR_W-1:0] step;
	logic              wait_calc;

	// Words per burst; zero means continuous, reserved codes run continuous too
	function automatic logic [4:0] fsbr_words(input logic [2:0] code);
		case (code)
			`FSBR_BL_4:  return 5'h04;
			`FSBR_BL_8:  return 5'h08;
			`FSBR_BL_16: return 5'h10;
			default:     return 5'h00;
		endcase
	endfunction : fsbr_words

	// Next word address of the linear burst sequence
	function automatic logic [ADDR_W-1:0] fsbr_step(input logic [ADDR_W-1:0] a,
			input logic [2:0] code, input logic nowrap);
		logic [ADDR_W-1:0] mask;
		logic [ADDR_W-1:0] inc;
		mask = ADDR_W'(fsbr_words(code)) - ADDR_W'(1);
		inc = a + ADDR_W'(1);
		if (fsbr_words(code) == 5'h00) begin
			return (&a) ? a : inc;
		end else if (nowrap) begin
			return inc;
		end else begin
			return (a & ~mask) | (inc & mask);
		end
	endfunction : fsbr_step

	// Row boundary wait states: none when 4-word aligned, latency minus one at worst
	function automatic logic [4:0] fsbr_end_of_wordline(input logic [3:0] lat, input logic [1:0] off);
		logic [4:0] lim;
		lim = {1'b0, lat} - 5'h01;
		if (off == 2'h0) begin
			return 5'h00;
		end else if (off == 2'h3) begin
			return lim;
		end else begin
			return ({3'h0, off} < lim) ? {3'h0, off} : lim;
		end
	endfunction : fsbr_end_of_wordline

	// Field decode; codes below the minimum run at the minimum latency
	assign rm        = read_configuration[`FSBR_MODE_BIT];
	assign lat_code  = read_configuration[`FSBR_LAT_HI:`FSBR_LAT_LO];
	assign lat_eff   = (lat_code < `FSBR_LAT_MIN) ? `FSBR_LAT_MIN : lat_code;
	assign wpol      = read_configuration[`FSBR_WPOL_BIT];
	assign wdly      = read_configuration[`FSBR_WDLY_BIT];
	assign edge_rise = read_configuration[`FSBR_EDGE_BIT];
	assign wrap_dis  = read_configuration[`FSBR_WRAP_BIT];
	assign bl        = read_configuration[`FSBR_BL_HI:`FSBR_BL_LO];

	// Synchronised pin view; the bus clock is sampled, not used as a clock
	assign fclk    = pin_s2[3];
	assign adv_n   = pin_s2[2];
	assign cs_n    = pin_s2[1];
	assign oe_n    = pin_s2[0];
	assign active  = !cs_n && !oe_n;
	assign edge_ok = edge_rise ? (fclk && !fclk_d) : (!fclk && fclk_d);
	assign capture = edge_ok && !adv_n && !cs_n;
	assign deliver = edge_ok && !capture &&
		((state == FSBR_LAT && hold_cnt == 5'h01) || state == FSBR_DATA);
	assign step    = fsbr_step(array_addr, bl, wrap_dis);

	// Next values of sequencer, pins and configuration
	always_comb begin
		next_state      = state;
		next_hold_cnt   = hold_cnt;
		next_words_left = words_left;
		next_end_of_wordline_left  = end_of_wordline_left;
		next_array_addr = array_addr;
		next_data_out   = data_out;
		next_wait_asrt  = wait_asrt;
		next_data_oe    = active;
		next_wait_oe    = active;
		next_cfg        = cfg_wr ? (cfg_wdata & `FSBR_CFG_WMASK) : read_configuration;
		if (rm) begin
			// Page mode: array follows the address pins, wait parked deasserted
			next_state      = FSBR_IDLE;
			next_array_addr = addr_s2;
			next_data_out   = array_rdata;
			if (edge_ok && active) begin
				next_wait_asrt = 1'b0;
			end
		end else if (cs_n) begin
			// Deselect aborts any burst
			next_state = FSBR_IDLE;
		end else if (capture) begin
			// Address taken on every selected edge with address valid low
			next_state      = FSBR_LAT;
			next_array_addr = addr_s2;
			next_hold_cnt   = {1'b0, lat_eff};
			next_words_left = fsbr_words(bl);
			next_end_of_wordline_left  = (addr_s2[3:0] != 4'h0 && (wrap_dis || fsbr_words(bl) == 5'h00))
				? fsbr_end_of_wordline(lat_eff, addr_s2[1:0]) : 5'h00;
		end else if (deliver) begin
			// One word per edge; the array read port settles within one mclk
			next_data_out = array_rdata;
			if (words_left == 5'h01 ||
					(fsbr_words(bl) == 5'h00 && (&array_addr))) begin
				next_state = FSBR_DONE;
			end else begin
				next_array_addr = step;
				next_words_left = (words_left == 5'h00) ? 5'h00 : words_left - 5'h01;
				next_state      = FSBR_DATA;
				if (step[3:0] == 4'h0) begin
					// Only the first row crossing can stall the burst
					next_end_of_wordline_left = 5'h00;
					if (end_of_wordline_left != 5'h00) begin
						next_state    = FSBR_LAT;
						next_hold_cnt = end_of_wordline_left + 5'h01;
					end
				end
			end
		end else if (edge_ok && state == FSBR_LAT) begin
			next_hold_cnt = hold_cnt - 5'h01;
		end
		// Wait follows the state after this edge, dropping early when delay is set
		wait_calc = (next_state == FSBR_LAT) && !(wdly && next_hold_cnt == 5'h01);
		if (!rm && edge_ok && active) begin
			next_wait_asrt = wait_calc;
		end
		next_wait_out = next_wait_asrt ? wpol : !wpol;
	end

	// Registers; reset selects page mode reads
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			pin_s1             <= 4'hF;
			pin_s2             <= 4'hF;
			addr_s1            <= '0;
			addr_s2            <= '0;
			fclk_d             <= 1'b1;
			state              <= FSBR_IDLE;
			hold_cnt           <= 5'h00;
			words_left         <= 5'h00;
			end_of_wordline_left          <= 5'h00;
			wait_asrt          <= 1'b0;
			array_addr         <= '0;
			data_out           <= 16'h0000;
			data_oe            <= 1'b0;
			wait_out           <= 1'b0;
			wait_oe            <= 1'b0;
			read_configuration <= `FSBR_CFG_RESET;
		end else begin
			pin_s1             <= {flash_clk, addr_valid_n, chip_sel_n, out_en_n};
			pin_s2             <= pin_s1;
			addr_s1            <= addr_in;
			addr_s2            <= addr_s1;
			fclk_d             <= pin_s2[3];
			state              <= next_state;
			hold_cnt           <= next_hold_cnt;
			words_left         <= next_words_left;
			end_of_wordline_left          <= next_end_of_wordline_left;
			wait_asrt          <= next_wait_asrt;
			array_addr         <= next_array_addr;
			data_out           <= next_data_out;
			data_oe            <= next_data_oe;
			wait_out           <= next_wait_out;
			wait_oe            <= next_wait_oe;
			read_configuration <= next_cfg;
		end
	end

	// Checking helpers: edges since capture while the first word is pending
	logic       first_pend;
	logic [4:0] dbg_edges;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			first_pend <= 1'b0;
			dbg_edges  <= 5'h00;
		end else if (!rm && !cs_n && capture) begin
			first_pend <= 1'b1;
			dbg_edges  <= 5'h00;
		end else if (deliver || cs_n || rm) begin
			first_pend <= 1'b0;
		end else if (edge_ok && first_pend) begin
			dbg_edges  <= dbg_edges + 5'h01;
		end
	end

	// First word lands on the latency-th edge after capture
	property p_first_latency;
		@(posedge mclk) disable iff (!rstn)
		(!rm && !cs_n && deliver && first_pend && $stable(read_configuration))
			|-> (dbg_edges == 5'({1'b0, lat_eff} - 5'h01));
	endproperty
	a_first_latency: assert property (p_first_latency) else $error("first word latency wrong");

	// Page mode keeps wait deasserted
	property p_async_wait;
		@(posedge mclk) disable iff (!rstn)
		(rm && $past(rm) && $past(wait_asrt) == 1'b0 && $stable(read_configuration))
			|-> (wait_out == !wpol && !wait_asrt);
	endproperty
	a_async_wait: assert property (p_async_wait) else $error("wait asserted in page mode");

	// Wait enable mirrors both selects low
	property p_wait_float;
		@(posedge mclk) disable iff (!rstn)
		(wait_oe == $past(active)) && (data_oe == wait_oe);
	endproperty
	a_wait_float: assert property (p_wait_float) else $error("wait enable wrong");

	// Driven level follows the polarity bit
	property p_wait_level;
		@(posedge mclk) disable iff (!rstn)
		$stable(wpol) |-> (wait_out == (wait_asrt ? wpol : !wpol));
	endproperty
	a_wait_level: assert property (p_wait_level) else $error("wait level wrong");

	// No wait change without a selected edge in an active cycle
	property p_wait_edge;
		@(posedge mclk) disable iff (!rstn)
		(!$past(edge_ok && active) && !$past(rm)) |-> $stable(wait_asrt);
	endproperty
	a_wait_edge: assert property (p_wait_edge) else $error("wait moved off edge");

	// Data streaming never shows wait asserted
	property p_data_valid;
		@(posedge mclk) disable iff (!rstn)
		(!rm && state == FSBR_DATA && $past(edge_ok && active)) |-> !wait_asrt;
	endproperty
	a_data_valid: assert property (p_data_valid) else $error("wait asserted with data");

	// Early drop only with delay set, on the last latency edge
	property p_wait_delay;
		@(posedge mclk) disable iff (!rstn)
		(!rm && state == FSBR_LAT && $past(edge_ok && active) && $stable(read_configuration))
			|-> (wait_asrt == !(wdly && hold_cnt == 5'h01));
	endproperty
	a_wait_delay: assert property (p_wait_delay) else $error("wait delay wrong");

	// Wrapping bursts stay inside their aligned block
	property p_wrap_block;
		logic [ADDR_W-1:0] m;
		@(posedge mclk) disable iff (!rstn)
		(!rm && deliver && !wrap_dis && fsbr_words(bl) != 5'h00 && words_left > 5'h01,
			m = ~(ADDR_W'(fsbr_words(bl)) - ADDR_W'(1)))
			|=> ((array_addr & m) == ($past(array_addr) & m)) &&
				(array_addr != $past(array_addr));
	endproperty
	a_wrap_block: assert property (p_wrap_block) else $error("wrap left block");

	// No-wrap and continuous bursts count straight up
	property p_linear;
		@(posedge mclk) disable iff (!rstn)
		(!rm && deliver && (wrap_dis || fsbr_words(bl) == 5'h00) && words_left != 5'h01 &&
			!(&array_addr)) |=> (array_addr == $past(array_addr) + ADDR_W'(1));
	endproperty
	a_linear: assert property (p_linear) else $error("linear step wrong");

	// Burst length code 16 sets a word count of sixteen
	property p_burst_len;
		@(posedge mclk) disable iff (!rstn)
		(!rm && capture && bl == `FSBR_BL_16 && !cs_n) |=> (words_left == 5'h10);
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("burst length wrong");

	// Burst order field never reads back set
	property p_order_zero;
		@(posedge mclk) disable iff (!rstn)
		read_configuration[7] == 1'b0;
	endproperty
	a_order_zero: assert property (p_order_zero) else $error("order bit set");

endmodule : fsbr_flash_burst

// File: rtl/fsbr_params.svh
// Register layout, encodings and limits of the synchronous burst read block
`ifndef FSBR_PARAMS_SVH
`define FSBR_PARAMS_SVH

// Reset value: async mode, latency 15, wait high, delay on, rising edge, no wrap, continuous
`define FSBR_CFG_RESET   16'hFD4F
// Writable bits; reserved bits and burst order stay zero
`define FSBR_CFG_WMASK   16'hFD4F

// Field positions
`define FSBR_MODE_BIT    15
`define FSBR_LAT_HI      14
`define FSBR_LAT_LO      11
`define FSBR_WPOL_BIT    10
`define FSBR_WDLY_BIT    8
`define FSBR_EDGE_BIT    6
`define FSBR_WRAP_BIT    3
`define FSBR_BL_HI       2
`define FSBR_BL_LO       0

// Burst length codes
`define FSBR_BL_4        3'h1
`define FSBR_BL_8        3'h2
`define FSBR_BL_16       3'h3
`define FSBR_BL_CONT     3'h7

// Smallest latency code the array can serve
`define FSBR_LAT_MIN     4'h5

`endif

// File: rtl/fsbr_pkg.sv
// Types shared by the synchronous burst read block
package fsbr_pkg;

	// Burst sequencer states
	typedef enum logic [1:0] {
		FSBR_IDLE,
		FSBR_LAT,
		FSBR_DATA,
		FSBR_DONE
	} fsbr_state_t;

endpackage : fsbr_pkg
